// ===== hw/prc_rate_changer.sv
// Purpose: Power-of-two decimator and interpolator with AXI4-Lite control
// Assumes: Upstream and downstream are logic on mclk; no back-pressure from downstream
// Notes:   Each halve or double stage is a 7-tap filter, narrow plain FIR or halfband
// Contract
// RULE1: Rate changes by two to the exponent, exponent zero to sixteen.
// RULE2: Exponent zero forwards every sample unfiltered, no rate change.
// RULE3: Upstream presents at most one sample per clock.
// RULE4: Decimator is sixteen cascaded stages, filter then keep one in two.
// RULE5: Decimation exponent selects which halving stage drives the output.
// RULE6: Each doubling stage inserts a zero per sample, then lowpass filters.
// RULE7: Interpolation exponent picks the entry stage; later stages chain on.
// RULE8: Narrow option is a plain FIR, passband 0.15, stopband 0.25.
// RULE9: Wide option is a halfband filter, passband 0.2, stopband 0.3.
// RULE10: Component width sets each part; complex bus is twice as wide.
// RULE11: Tag bits of configurable width accompany every sample.
// RULE12: Tags and last travel with data, marking the group delay sample.
// RULE13: Each halving stage records its phase as the trigger passes.
// RULE14: Consumer masks phase to low exponent bits as input periods.
// RULE15: Output valid only for kept or generated samples; no ready input.
// RULE16: Reset clears filter state and phases; valid low until refilled.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "prc_consts.svh"
module prc_rate_changer
    import prc_pkg::*;
#(
    parameter int CW      = 16,
    parameter int COMPLEX = 0,
    parameter int TU      = 1
)
(
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic [`PRC_ADDR_W-1:0]    s_axil_awaddr,
    input  wire logic                      s_axil_awvalid,
    output wire logic                      s_axil_awready,
    input  wire logic [31:0]               s_axil_wdata,
    input  wire logic [3:0]                s_axil_wstrb,
    input  wire logic                      s_axil_wvalid,
    output wire logic                      s_axil_wready,
    output wire logic [1:0]                s_axil_bresp,
    output wire logic                      s_axil_bvalid,
    input  wire logic                      s_axil_bready,
    input  wire logic [`PRC_ADDR_W-1:0]    s_axil_araddr,
    input  wire logic                      s_axil_arvalid,
    output wire logic                      s_axil_arready,
    output wire logic [31:0]               s_axil_rdata,
    output wire logic [1:0]                s_axil_rresp,
    output wire logic                      s_axil_rvalid,
    input  wire logic                      s_axil_rready,
    input  wire logic                      dec_s_tvalid,
    input  wire logic [(COMPLEX+1)*CW-1:0] dec_s_tdata,
    input  wire logic [TU-1:0]             dec_s_tuser,
    input  wire logic                      dec_s_tlast,
    output wire logic                      dec_m_tvalid,
    output wire logic [(COMPLEX+1)*CW-1:0] dec_m_tdata,
    output wire logic [TU-1:0]             dec_m_tuser,
    output wire logic                      dec_m_tlast,
    output wire logic [`PRC_NSTAGE-1:0]    trigger_phase_out,
    input  wire logic                      int_s_tvalid,
    output wire logic                      int_s_tready,
    input  wire logic [(COMPLEX+1)*CW-1:0] int_s_tdata,
    input  wire logic [TU-1:0]             int_s_tuser,
    input  wire logic                      int_s_tlast,
    output wire logic                      int_m_tvalid,
    output wire logic [(COMPLEX+1)*CW-1:0] int_m_tdata,
    output wire logic [TU-1:0]             int_m_tuser,
    output wire logic                      int_m_tlast
);
    // RULE10: complex bus doubling
    localparam int NC  = COMPLEX + 1;
    localparam int DW  = NC * CW;
    localparam int NST = `PRC_NSTAGE;
    localparam int NT  = `PRC_TAPS;
    localparam int AW  = CW + 7;
    localparam int FW  = DW + TU + 1;
    localparam int LW  = $clog2(`PRC_FIFO_DEPTH) + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    function automatic logic [`PRC_EXP_W-1:0] clamp_exp(input logic [`PRC_EXP_W-1:0] e);
        clamp_exp = (e > `PRC_EXP_W'(`PRC_MAX_EXP)) ? `PRC_EXP_W'(`PRC_MAX_EXP) : e;
    endfunction

    function automatic logic [CW-1:0] sat(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi;
        logic signed [AW-1:0] lo;
        hi = AW'({1'b0, {(CW-1){1'b1}}});
        lo = ~hi;
        sat = (v > hi) ? hi[CW-1:0] : ((v < lo) ? lo[CW-1:0] : v[CW-1:0]);
    endfunction

    // Coefficients in 1/32; interpolation doubles gain to make up for stuffed zeros
    function automatic logic [DW-1:0] fir(input logic [NT-1:0][DW-1:0] t, input logic hb, input logic up);
        logic signed [AW-1:0] x [NT];
        logic signed [AW-1:0] acc;
        logic [DW-1:0]        r;
        r = '0;
        for (int c = 0; c < NC; c++)
        begin
            for (int k = 0; k < NT; k++)
                x[k] = AW'(signed'(t[k][c*CW +: CW]));
            // RULE9: halfband taps
            if (hb)
                acc = ((x[2] + x[4]) <<< 3) + x[2] + x[4] + (x[3] <<< 4) - x[0] - x[6];
            // RULE8: plain FIR taps
            else
                acc = x[0] + x[6] + ((x[1] + x[5]) <<< 2) + ((x[2] + x[4]) <<< 3) - x[2] - x[4] + (x[3] <<< 3);
            r[c*CW +: CW] = sat(up ? (acc >>> 4) : (acc >>> 5));
        end
        fir = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus

    prc_bus_st_t                wst_r;
    logic                       aw_got_r;
    logic                       w_got_r;
    logic [`PRC_ADDR_W-1:0]     awaddr_r;
    logic [31:0]                wdata_r;
    logic [3:0]                 wstrb_r;
    logic [1:0]                 bresp_r;
    logic                       rvalid_r;
    logic [31:0]                rdata_r;
    logic [1:0]                 rresp_r;
    logic [31:0]                ctrl_r;
    logic                       flush_r;
    logic [LW-1:0]              fifo_level;

    wire                        aw_take  = s_axil_awvalid & s_axil_awready;
    wire                        w_take   = s_axil_wvalid & s_axil_wready;
    wire                        wr_do    = (wst_r == PRC_IDLE) & aw_got_r & w_got_r;
    wire                        wr_ctrl  = awaddr_r == `PRC_OFF_CTRL;
    wire                        ar_take  = s_axil_arvalid & s_axil_arready;
    wire [31:0]                 ctrl_nxt;
    wire [`PRC_EXP_W-1:0]       dec_exp  = ctrl_r[`PRC_CTRL_DEC_LSB +: `PRC_EXP_W];
    wire [`PRC_EXP_W-1:0]       int_exp  = ctrl_r[`PRC_CTRL_INT_LSB +: `PRC_EXP_W];
    wire                        filt_hb  = ctrl_r[`PRC_CTRL_FILT_BIT] == PRC_HALFBAND;
    wire                        clr      = reset | flush_r;
    wire                        rd_map   = (s_axil_araddr == `PRC_OFF_CTRL) | (s_axil_araddr == `PRC_OFF_PHASE)
                                         | (s_axil_araddr == `PRC_OFF_LEVEL);
    wire [31:0]                 rd_mux   = (s_axil_araddr == `PRC_OFF_CTRL)  ? ctrl_r :
                                           (s_axil_araddr == `PRC_OFF_PHASE) ? 32'(trigger_phase_out) :
                                           (s_axil_araddr == `PRC_OFF_LEVEL) ? 32'(fifo_level) : 32'h0000_0000;

    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_strb
            assign ctrl_nxt[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : ctrl_r[b*8 +: 8];
        end
    endgenerate

    assign s_axil_awready = ~aw_got_r & (wst_r == PRC_IDLE);
    assign s_axil_wready  = ~w_got_r & (wst_r == PRC_IDLE);
    assign s_axil_bvalid  = wst_r == PRC_RESP;
    assign s_axil_bresp   = bresp_r;
    assign s_axil_arready = ~rvalid_r;
    assign s_axil_rvalid  = rvalid_r;
    assign s_axil_rdata   = rdata_r;
    assign s_axil_rresp   = rresp_r;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wst_r    <= PRC_IDLE;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
            bresp_r  <= `PRC_RESP_OKAY;
            ctrl_r   <= `PRC_CTRL_RST;
            flush_r  <= 1'b0;
        end
        else
        begin
            flush_r <= 1'b0;
            if (aw_take)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axil_awaddr;
            end
            if (w_take)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axil_wdata;
                wstrb_r <= s_axil_wstrb;
            end
            if (wr_do)
            begin
                wst_r    <= PRC_RESP;
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bresp_r  <= wr_ctrl ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
                // RULE1: exponents held at sixteen most
                if (wr_ctrl)
                begin
                    ctrl_r  <= {ctrl_nxt[31:`PRC_CTRL_INT_LSB+`PRC_EXP_W],
                                clamp_exp(ctrl_nxt[`PRC_CTRL_INT_LSB +: `PRC_EXP_W]),
                                ctrl_nxt[`PRC_CTRL_INT_LSB-1:`PRC_CTRL_DEC_LSB+`PRC_EXP_W],
                                clamp_exp(ctrl_nxt[`PRC_CTRL_DEC_LSB +: `PRC_EXP_W])};
                    flush_r <= 1'b1;
                end
            end
            else if ((wst_r == PRC_RESP) & s_axil_bready)
                wst_r <= PRC_IDLE;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `PRC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_map ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
        end
        else if (s_axil_rready)
            rvalid_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decimator: index 0 is the input, index s+1 the output of halving stage s

    logic [NST:0]       dv;
    logic [DW-1:0]      dd [NST+1];
    // RULE11: tag per sample
    logic [TU-1:0]      du [NST+1];
    logic [NST:0]       dl;
    logic [NST-1:0]     phase_r;
    logic               dov_r;
    logic [DW-1:0]      dod_r;
    logic [TU-1:0]      dou_r;
    logic               dol_r;

    assign dv[0] = dec_s_tvalid;
    assign dd[0] = dec_s_tdata;
    assign du[0] = dec_s_tuser;
    assign dl[0] = dec_s_tlast;

    genvar s;
    generate
        for (s = 0; s < NST; s++)
        begin : g_dec
            logic [NT-1:0][DW-1:0]  line_r;
            logic [NT-1:0][TU-1:0]  tag_r;
            logic [NT-1:0]          last_r;
            logic                   keep_r;
            logic                   ov_r;
            logic [DW-1:0]          od_r;
            logic [TU-1:0]          ou_r;
            logic                   ol_r;
            wire [NT-1:0][DW-1:0]   nl = {line_r[NT-2:0], dd[s]};
            wire [NT-1:0][TU-1:0]   nu = {tag_r[NT-2:0], du[s]};
            wire [NT-1:0]           nt = {last_r[NT-2:0], dl[s]};

            assign dv[s+1] = ov_r;
            assign dd[s+1] = od_r;
            assign du[s+1] = ou_r;
            assign dl[s+1] = ol_r;

            // RULE16: clear state and phase
            always_ff @(posedge mclk)
            begin
                if (clr)
                begin
                    line_r     <= '0;
                    tag_r      <= '0;
                    last_r     <= '0;
                    keep_r     <= 1'b0;
                    ov_r       <= 1'b0;
                    od_r       <= '0;
                    ou_r       <= '0;
                    ol_r       <= 1'b0;
                    phase_r[s] <= 1'b0;
                end
                else
                begin
                    // RULE15: valid only on kept samples
                    ov_r <= dv[s] & keep_r;
                    if (dv[s])
                    begin
                        line_r <= nl;
                        tag_r  <= nu;
                        last_r <= nt;
                        keep_r <= ~keep_r;
                    end
                    // RULE4: filter then keep one of two
                    if (dv[s] & keep_r)
                    begin
                        od_r <= fir(nl, filt_hb, 1'b0);
                        // RULE12: tag at filter centre
                        ou_r <= nu[3] | nu[2];
                        ol_r <= nt[3] | nt[2];
                        // RULE13: phase caught with trigger
                        if (nu[3][0] | nu[2][0])
                            phase_r[s] <= ~nu[3][0];
                    end
                end
            end
        end
    endgenerate

    // RULE5: exponent selects stage output
    wire [`PRC_EXP_W-1:0] dsel = dec_exp;

    always_ff @(posedge mclk)
    begin
        if (clr)
        begin
            dov_r <= 1'b0;
            dod_r <= '0;
            dou_r <= '0;
            dol_r <= 1'b0;
        end
        else
        begin
            // RULE2: index zero is the raw input
            dov_r <= dv[dsel];
            dod_r <= dd[dsel];
            dou_r <= du[dsel];
            dol_r <= dl[dsel];
        end
    end

    assign dec_m_tvalid      = dov_r;
    assign dec_m_tdata       = dod_r;
    assign dec_m_tuser       = dou_r;
    assign dec_m_tlast       = dol_r;
    // RULE14: consumer masks low exponent bits
    assign trigger_phase_out = phase_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Interpolator: FIFO paces the input at one sample per 2^n cycles

    logic               fv;
    logic [FW-1:0]      fd;
    logic [NST:0]       tick_r;
    logic [NST:0]       iv;
    logic [DW-1:0]      id [NST+1];
    logic [TU-1:0]      iu [NST+1];
    logic [NST:0]       il;
    logic               iov_r;
    logic [DW-1:0]      iod_r;
    logic [TU-1:0]      iou_r;
    logic               iol_r;

    // RULE3: one sample per clock at most
    wire                        pop    = fv & (tick_r == '0);
    wire [`PRC_EXP_W-1:0]       entry  = `PRC_EXP_W'(NST) - int_exp;

    prc_fifo #(.W(FW), .DEPTH(`PRC_FIFO_DEPTH)) u_fifo
    (
        .mclk    (mclk),
        .reset   (reset),
        .clear   (flush_r),
        .s_valid (int_s_tvalid),
        .s_ready (int_s_tready),
        .s_data  ({int_s_tlast, int_s_tuser, int_s_tdata}),
        .m_valid (fv),
        .m_ready (pop),
        .m_data  (fd),
        .level   (fifo_level)
    );

    always_ff @(posedge mclk)
    begin
        if (clr)
            tick_r <= '0;
        else if (pop)
            tick_r <= ((NST+1)'(1) << int_exp) - 1'b1;
        else if (tick_r != '0)
            tick_r <= tick_r - 1'b1;
    end

    assign iv[0] = 1'b0;
    assign id[0] = '0;
    assign iu[0] = '0;
    assign il[0] = 1'b0;

    generate
        for (s = 0; s < NST; s++)
        begin : g_int
            localparam logic [NST-1:0] HALF = NST'((1 << (NST - 1 - s)) - 1);
            logic [NT-1:0][DW-1:0]  line_r;
            logic [NT-1:0][TU-1:0]  tag_r;
            logic [NT-1:0]          last_r;
            logic                   pend_r;
            logic                   plast_r;
            logic [NST-1:0]         cnt_r;
            logic                   ov_r;
            logic [DW-1:0]          od_r;
            logic [TU-1:0]          ou_r;
            logic                   ol_r;
            // RULE7: entry stage takes FIFO, later ones chain
            wire                    here = `PRC_EXP_W'(s) == entry;
            wire                    in_v = here ? pop : (`PRC_EXP_W'(s) > entry) & iv[s];
            wire [DW-1:0]           in_d = here ? fd[DW-1:0] : id[s];
            wire [TU-1:0]           in_u = here ? fd[DW +: TU] : iu[s];
            wire                    in_l = here ? fd[FW-1] : il[s];
            wire                    zero = ~in_v & pend_r & (cnt_r == '0);
            wire                    step = in_v | zero;
            // RULE6: zero inserted after each sample
            wire [NT-1:0][DW-1:0]   nl = {line_r[NT-2:0], in_v ? in_d : DW'(0)};
            wire [NT-1:0][TU-1:0]   nu = {tag_r[NT-2:0], in_v ? in_u : TU'(0)};
            wire [NT-1:0]           nt = {last_r[NT-2:0], zero & plast_r};

            assign iv[s+1] = ov_r;
            assign id[s+1] = od_r;
            assign iu[s+1] = ou_r;
            assign il[s+1] = ol_r;

            always_ff @(posedge mclk)
            begin
                if (clr)
                begin
                    line_r  <= '0;
                    tag_r   <= '0;
                    last_r  <= '0;
                    pend_r  <= 1'b0;
                    plast_r <= 1'b0;
                    cnt_r   <= '0;
                    ov_r    <= 1'b0;
                    od_r    <= '0;
                    ou_r    <= '0;
                    ol_r    <= 1'b0;
                end
                else
                begin
                    // RULE15: every generated sample valid
                    ov_r <= step;
                    if (step)
                    begin
                        line_r <= nl;
                        tag_r  <= nu;
                        last_r <= nt;
                        od_r   <= fir(nl, filt_hb, 1'b1);
                        // RULE12: tag and last at centre
                        ou_r   <= nu[3];
                        ol_r   <= nt[3];
                    end
                    if (in_v)
                    begin
                        pend_r  <= 1'b1;
                        plast_r <= in_l;
                        cnt_r   <= HALF;
                    end
                    else if (zero)
                        pend_r <= 1'b0;
                    else if (pend_r)
                        cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    endgenerate

    // Bypass takes the FIFO head directly, so exponent zero adds no filtering
    always_ff @(posedge mclk)
    begin
        if (clr)
        begin
            iov_r <= 1'b0;
            iod_r <= '0;
            iou_r <= '0;
            iol_r <= 1'b0;
        end
        // RULE2: bypass at exponent zero
        else if (int_exp == '0)
        begin
            iov_r <= pop;
            iod_r <= fd[DW-1:0];
            iou_r <= fd[DW +: TU];
            iol_r <= fd[FW-1];
        end
        else
        begin
            iov_r <= iv[NST];
            iod_r <= id[NST];
            iou_r <= iu[NST];
            iol_r <= il[NST];
        end
    end

    assign int_m_tvalid = iov_r;
    assign int_m_tdata  = iod_r;
    assign int_m_tuser  = iou_r;
    assign int_m_tlast  = iol_r;
endmodule

// ===== inc/prc_consts.svh
// Purpose: Rate changer constants
// Assumes: Included by bare name from the rate changer design file
// Notes:   Definitions only
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

`define PRC_NSTAGE        16
`define PRC_MAX_EXP       16
`define PRC_EXP_W         5
`define PRC_TAPS          7
`define PRC_FIFO_DEPTH    32
`define PRC_ADDR_W        8
`define PRC_OFF_CTRL      8'h00
`define PRC_OFF_PHASE     8'h04
`define PRC_OFF_LEVEL     8'h08
`define PRC_CTRL_DEC_LSB  0
`define PRC_CTRL_INT_LSB  8
`define PRC_CTRL_FILT_BIT 16
`define PRC_CTRL_RST      32'h0000_0000
`define PRC_RESP_OKAY     2'b00
`define PRC_RESP_SLVERR   2'b10

`endif

// ===== inc/prc_pkg.sv
// Purpose: Rate changer types
// Assumes: Nothing
// Notes:   Constants live in prc_consts.svh
package prc_pkg;

    typedef enum logic [1:0]
    {
        PRC_IDLE = 2'b00,
        PRC_RESP = 2'b01
    } prc_bus_st_t;

    typedef enum logic
    {
        PRC_NARROW   = 1'b0,
        PRC_HALFBAND = 1'b1
    } prc_filt_t;

endpackage

// ===== hw/prc_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Read data is taken straight from the storage flops
`timescale 1ns/1ps
module prc_fifo
#(
    parameter int W     = 8,
    parameter int DEPTH = 32
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic                   clear,
    input  wire logic                   s_valid,
    output wire logic                   s_ready,
    input  wire logic [W-1:0]           s_data,
    output wire logic                   m_valid,
    input  wire logic                   m_ready,
    output wire logic [W-1:0]           m_data,
    output wire logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_r;
    logic [AW:0]  rd_r;

    wire push = s_valid & s_ready;
    wire pop  = m_valid & m_ready;

    assign level   = wr_r - rd_r;
    assign s_ready = level != (AW+1)'(DEPTH);
    assign m_valid = level != '0;
    assign m_data  = mem[rd_r[AW-1:0]];

    always_ff @(posedge mclk)
    begin
        if (reset | clear)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_r[AW-1:0]] <= s_data;
    end
endmodule

// ===== bench/prc_rate_changer_sva.sv
// Purpose: Port checks on the rate changer
// Assumes: One clock, synchronous reset
// Notes:   Bound to every design instance
`timescale 1ns/1ps
module prc_rate_changer_sva
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        s_axil_awvalid,
    input wire logic        s_axil_awready,
    input wire logic        s_axil_wvalid,
    input wire logic        s_axil_wready,
    input wire logic        s_axil_bvalid,
    input wire logic        s_axil_bready,
    input wire logic        s_axil_arvalid,
    input wire logic        s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0]  s_axil_rresp,
    input wire logic        s_axil_rvalid,
    input wire logic        s_axil_rready,
    input wire logic        dec_m_tvalid,
    input wire logic        int_m_tvalid,
    input wire logic [15:0] trigger_phase_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wr_answer_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
        |=> !s_axil_bvalid ##1 s_axil_bvalid) else $error("write answer timing");
    wr_block_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready) else $error("write taken");
    b_done_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid) else $error("bvalid stuck");
    rd_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid) else $error("read late");
    rd_block_a: assert property (s_axil_rvalid |-> !s_axil_arready) else $error("read taken");
    r_done_a: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid) else $error("rvalid stuck");
    rd_err_a: assert property (s_axil_rvalid && s_axil_rresp == 2'b10 |-> s_axil_rdata == 32'h0)
        else $error("error read data");
    reset_quiet_a: assert property ($past(reset) |-> !dec_m_tvalid && !int_m_tvalid &&
        trigger_phase_out == 16'h0) else $error("output after reset");
endmodule
bind prc_rate_changer prc_rate_changer_sva chk (.*);

// ===== bench/prc_up_src.sv
// Purpose: Upstream stream source model
// Assumes: One sample per clock at most
// Notes:   Idle data toggles so stale values never pass
`timescale 1ns/1ps
module prc_up_src
(
    input  wire logic        mclk,
    input  wire logic        run,
    input  wire logic        ready,
    input  wire logic [15:0] value,
    output logic             tvalid = 1'b0,
    output logic [15:0]      tdata = 16'h0
);
    always @(posedge mclk)
        if (!tvalid || ready)
        begin
            tvalid <= run;
            tdata  <= run ? value : ~tdata;
        end
endmodule

// ===== bench/prc_rate_changer_tb.sv
// Purpose: Self-checking bench for the rate changer
// Assumes: Real data, 16-bit parts, one tag bit
// Notes:   Fixed waits let each pipeline drain
`timescale 1ns/1ps
module prc_rate_changer_tb;
    logic mclk = 0, reset = 1, s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0;
    logic s_axil_rready = 0, run_d = 0, run_i = 0, s_axil_awready, s_axil_wready, s_axil_bvalid;
    logic s_axil_arready, s_axil_rvalid, dec_s_tvalid, dec_m_tvalid, int_s_tvalid, int_s_tready, int_m_tvalid;
    logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
    logic [31:0] s_axil_wdata = 0, s_axil_rdata;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [15:0] val = 0, dec_s_tdata, int_s_tdata, dec_m_tdata, dlast;
    int cyc = 0, dn = 0, in_n = 0, bad_count = 0, cmp_count = 0;
    initial forever #2.5 mclk = ~mclk;
    prc_rate_changer dut (.*, .s_axil_wstrb(4'hf), .dec_s_tuser(dec_s_tdata[0]), .dec_s_tlast(1'b0),
        .dec_m_tuser(), .dec_m_tlast(), .trigger_phase_out(), .int_s_tuser(1'b0), .int_s_tlast(1'b0),
        .int_m_tdata(), .int_m_tuser(), .int_m_tlast());
    prc_up_src src_d (.mclk, .run(run_d), .ready(1'b1), .value(val), .tvalid(dec_s_tvalid), .tdata(dec_s_tdata));
    prc_up_src src_i (.mclk, .run(run_i), .ready(int_s_tready), .value(val), .tvalid(int_s_tvalid),
        .tdata(int_s_tdata));
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        dn <= dn + int'(dec_m_tvalid);
        in_n <= in_n + int'(int_m_tvalid);
        if (dec_m_tvalid)
            dlast <= dec_m_tdata;
        if (cyc == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(string n, logic [31:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axil_awready)
                s_axil_awvalid <= 1'b0;
            if (s_axil_wready)
                s_axil_wvalid <= 1'b0;
        end while (!s_axil_bvalid);
        s_axil_bready <= 1'b0;
        chk("bresp", er, s_axil_bresp);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axil_arready)
                s_axil_arvalid <= 1'b0;
        end while (!s_axil_rvalid);
        s_axil_rready <= 1'b0;
        chk("rresp", er, s_axil_rresp);
        chk("rdata", ed, s_axil_rdata);
    endtask
    task automatic feed(bit dec, logic [15:0] v, int n, ctrl);
        wr(8'h00, ctrl, 2'b00);
        val <= v;
        run_d <= dec;
        run_i <= !dec;
        repeat (n) @(posedge mclk);
        run_d <= 1'b0;
        run_i <= 1'b0;
        repeat (100) @(posedge mclk);
    endtask
    task automatic t_stream(bit dec, int ctrl, n, exp_n);
        int d0;
        d0 = dec ? dn : in_n;
        feed(dec, 16'h0100, n, ctrl);
        chk("sample count", exp_n, (dec ? dn : in_n) - d0);
        if (dec)
            chk("dc level", 32'h0100, dlast);
    endtask
    task automatic t_fifo();
        feed(1'b0, 16'h0040, 40, 32'h1000);
        chk("tready", 0, int_s_tready);
        rd(8'h08, 32'h20, 2'b00);
        wr(8'h00, 32'h0, 2'b00);
        repeat (5) @(posedge mclk);
        rd(8'h08, 32'h0, 2'b00);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h00, 32'h0, 2'b00);
        rd(8'h0c, 32'h0, 2'b10);
        wr(8'h04, 32'h1, 2'b10);
        t_stream(1'b1, 32'h0, 10, 10);
        t_stream(1'b1, 32'h2, 64, 16);
        rd(8'h04, 32'h0, 2'b00);
        t_stream(1'b0, 32'h300, 4, 32);
        t_fifo();
        wrap_up();
    end
endmodule
